// ---- rtl/vmon_pkg.sv ----
// Constants shared by the voltage monitor control block.
// Assumes a 250 MHz system clock and an AXI4-Lite master.
//
// What this block does
// - Code 000 compares external sense pin, 1.23V.
// - Codes 001-111 compare supply against fixed levels.
// - Bit 5 reads 1 while voltage is low.
// - Bit 4 switches detector on or off.
// - Reference on with detector, LOW_VOLTAGE_RESET or bit 3.
// - Bits 7-6 pick low duration before interrupt.
// - Sleep mode holds detector disabled always.
// - Request set after qualified low duration or by a write to OFF_SET.
// - New request from the filter wakes device from idle mode; a write to OFF_SET does not.
package vmon_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned OSC_PERIOD_NS = 31250;
  localparam int unsigned OSC_DIV_CYC   = OSC_PERIOD_NS * CLK_MHZ / 1000;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned AW = 8;
  localparam logic [AW-1:0] OFF_CTRL = 8'h00;
  localparam logic [AW-1:0] OFF_STAT = 8'h04;
  localparam logic [AW-1:0] OFF_CLR  = 8'h08;
  localparam logic [AW-1:0] OFF_IEN  = 8'h0c;
  localparam logic [AW-1:0] OFF_SET  = 8'h10;

  localparam int unsigned BIT_THR_LO  = 0;
  localparam int unsigned BIT_THR_HI  = 2;
  localparam int unsigned BIT_REF     = 3;
  localparam int unsigned BIT_EN      = 4;
  localparam int unsigned BIT_FLAG    = 5;
  localparam int unsigned BIT_FILT_LO = 6;
  localparam int unsigned BIT_FILT_HI = 7;

  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [7:0]  CTRL_WMASK = 8'hdf;
  localparam logic [2:0]  THR_EXT    = 3'h0;
  localparam logic [1:0]  RESP_OK    = 2'h0;
  localparam logic [1:0]  RESP_ERR   = 2'h2;

  // ----------------------------------------------------------------
  // Filter selection and tick counts
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FILT_SHORT = 2'b00,
    FILT_MID   = 2'b01,
    FILT_LONG  = 2'b10,
    FILT_ALT   = 2'b11
  } vmon_filt_t;

  localparam logic [3:0] TICKS_SHORT = 4'h2;
  localparam logic [3:0] TICKS_MID   = 4'h4;
  localparam logic [3:0] TICKS_LONG  = 4'h8;

  // ----------------------------------------------------------------
  // Bus channel states
  // ----------------------------------------------------------------
  typedef enum logic {
    WR_IDLE = 1'b0,
    WR_RESP = 1'b1
  } vmon_wr_t;

  typedef enum logic {
    RD_IDLE = 1'b0,
    RD_DATA = 1'b1
  } vmon_rd_t;

endpackage

// ---- rtl/vmon_filter.sv ----
// Qualifying filter: counts slow ticks while the low level holds.
// Assumes tick is a one-cycle enable from the slow divider.
`timescale 1ns/100ps
`default_nettype none
module vmon_filter (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Qualification
  input  wire logic       tick,
  input  wire logic       level,
  input  wire logic [3:0] need,
  output logic            hit
);
  import vmon_pkg::*;

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic       at_last;

  // ----------------------------------------------------------------
  // Tick counter, saturating once qualified
  // ----------------------------------------------------------------
  assign at_last = (cnt_q == need - 4'h1);
  assign hit     = level && tick && at_last;
  assign cnt_d   = !level ? 4'h0 :
                   (tick && cnt_q < need) ? cnt_q + 4'h1 : cnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_filt_clear;
    !level |=> (cnt_q == 4'h0);
  endproperty
  a_filt_clear: assert property (p_filt_clear)
    else $error("filter count not cleared by high voltage");

  property p_filt_hold;
    hit |-> $past(level) && (cnt_q == need - 4'h1);
  endproperty
  a_filt_hold: assert property (p_filt_hold)
    else $error("qualified without preceding low level");

endmodule
`default_nettype wire

// ---- rtl/vmon_ctrl.sv ----
// Voltage monitor control: register, filter, request flag, wake.
// Assumes the analog comparator result is synchronous to CLK_SYS.
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module vmon_ctrl #(
  parameter int unsigned OSC_DIV = vmon_pkg::OSC_DIV_CYC
) (
  // Clock and reset
  input  wire logic                      CLK_SYS,
  input  wire logic                      RST_N,
  // AXI4-Lite write address and data
  input  wire logic                      AWVALID,
  output logic                           AWREADY,
  input  wire logic [vmon_pkg::AW-1:0]   AWADDR,
  input  wire logic [2:0]                AWPROT,
  input  wire logic                      WVALID,
  output logic                           WREADY,
  input  wire logic [31:0]               WDATA,
  input  wire logic [3:0]                WSTRB,
  // AXI4-Lite write response
  output logic                           BVALID,
  input  wire logic                      BREADY,
  output logic [1:0]                     BRESP,
  // AXI4-Lite read
  input  wire logic                      ARVALID,
  output logic                           ARREADY,
  input  wire logic [vmon_pkg::AW-1:0]   ARADDR,
  input  wire logic [2:0]                ARPROT,
  output logic                           RVALID,
  input  wire logic                      RREADY,
  output logic [31:0]                    RDATA,
  output logic [1:0]                     RRESP,
  // Power mode and analog side
  input  wire logic                      SLEEP_MODE,
  input  wire logic                      IDLE_MODE,
  input  wire logic                      LVR_ENABLE,
  input  wire logic                      CMP_LOW,
  output logic                           MONITOR_ON,
  output logic                           REF_ON,
  output logic                           SENSE_EXT,
  output logic [2:0]                     THRESHOLD_SELECT,
  // Interrupt and wake
  output logic                           MONITOR_IRQ_REQUEST,
  output logic                           IRQ,
  output logic                           WAKE_IDLE
);
  import vmon_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  vmon_wr_t          wr_q;
  vmon_rd_t          rd_q;
  logic              aw_got_q;
  logic              w_got_q;
  logic [AW-1:0]     awaddr_q;
  logic [7:0]        wbyte_q;
  logic              wlane_q;
  logic [1:0]        bresp_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic [7:0]        ctrl_q;
  logic              low_q;
  logic              stat_q;
  logic              stat_d;
  logic              ien_q;
  logic              wake_q;
  logic [15:0]       div_q;
  logic              tick;
  logic              hit;
  logic              active;
  logic              do_wr;
  logic              wr_ctrl;
  logic              wr_clr;
  logic              wr_ien;
  logic              wr_set;
  logic              wr_ok;
  logic              rd_take;
  logic [31:0]       rd_val;
  logic              rd_ok;
  logic [3:0]        need;
  logic [7:0]        ctrl_view;
  logic [15:0]       div_last;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  assign AWREADY = (wr_q == WR_IDLE) && !aw_got_q;
  assign WREADY  = (wr_q == WR_IDLE) && !w_got_q;
  assign do_wr   = (wr_q == WR_IDLE) && aw_got_q && w_got_q;
  assign wr_ctrl = do_wr && (awaddr_q == OFF_CTRL) && wlane_q;
  assign wr_clr  = do_wr && (awaddr_q == OFF_CLR) && wlane_q;
  assign wr_ien  = do_wr && (awaddr_q == OFF_IEN) && wlane_q;
  assign wr_set  = do_wr && (awaddr_q == OFF_SET) && wlane_q;
  assign wr_ok   = (awaddr_q == OFF_CTRL) || (awaddr_q == OFF_STAT) ||
                   (awaddr_q == OFF_CLR) || (awaddr_q == OFF_IEN) ||
                   (awaddr_q == OFF_SET);
  assign BVALID  = (wr_q == WR_RESP);
  assign BRESP   = bresp_q;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      aw_got_q <= 1'b0;
      awaddr_q <= '0;
    end else if (AWVALID && AWREADY) begin
      aw_got_q <= 1'b1;
      awaddr_q <= AWADDR;
    end else if (do_wr) begin
      aw_got_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      w_got_q <= 1'b0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
    end else if (WVALID && WREADY) begin
      w_got_q <= 1'b1;
      wbyte_q <= WDATA[7:0];
      wlane_q <= WSTRB[0];
    end else if (do_wr) begin
      w_got_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      wr_q    <= WR_IDLE;
      bresp_q <= RESP_OK;
    end else begin
      case (wr_q)
        WR_IDLE: begin
          if (do_wr) begin
            wr_q    <= WR_RESP;
            bresp_q <= wr_ok ? RESP_OK : RESP_ERR;
          end
        end
        WR_RESP: begin
          if (BREADY) begin
            wr_q <= WR_IDLE;
          end
        end
        default: wr_q <= WR_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign ARREADY   = (rd_q == RD_IDLE);
  assign rd_take   = ARVALID && ARREADY;
  assign ctrl_view = {ctrl_q[BIT_FILT_HI:BIT_FILT_LO], low_q,
                      ctrl_q[BIT_EN:BIT_THR_LO]};
  assign rd_val    = (ARADDR == OFF_CTRL) ? {24'h000000, ctrl_view} :
                     (ARADDR == OFF_STAT) ? {31'h00000000, stat_q} :
                     (ARADDR == OFF_IEN)  ? {31'h00000000, ien_q} :
                     32'h00000000;
  assign rd_ok     = (ARADDR == OFF_CTRL) || (ARADDR == OFF_STAT) ||
                     (ARADDR == OFF_CLR) || (ARADDR == OFF_IEN) ||
                     (ARADDR == OFF_SET);
  assign RVALID    = (rd_q == RD_DATA);
  assign RDATA     = rdata_q;
  assign RRESP     = rresp_q;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rd_q    <= RD_IDLE;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OK;
    end else begin
      case (rd_q)
        RD_IDLE: begin
          if (rd_take) begin
            rd_q    <= RD_DATA;
            rdata_q <= rd_val;
            rresp_q <= rd_ok ? RESP_OK : RESP_ERR;
          end
        end
        RD_DATA: begin
          if (RREADY) begin
            rd_q <= RD_IDLE;
          end
        end
        default: rd_q <= RD_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control register and analog controls
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= CTRL_RST;
      ien_q  <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wbyte_q & CTRL_WMASK;
      end
      if (wr_ien) begin
        ien_q <= wbyte_q[0];
      end
    end
  end

  assign active           = ctrl_q[BIT_EN] && !SLEEP_MODE;
  assign MONITOR_ON       = active;
  assign REF_ON           = ctrl_q[BIT_EN] || LVR_ENABLE ||
                            ctrl_q[BIT_REF];
  assign THRESHOLD_SELECT = ctrl_q[BIT_THR_HI:BIT_THR_LO];
  assign SENSE_EXT        = (THRESHOLD_SELECT == THR_EXT);

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      low_q <= 1'b0;
    end else begin
      low_q <= active && CMP_LOW;
    end
  end

  // ----------------------------------------------------------------
  // Slow oscillator tick and qualifying filter
  // ----------------------------------------------------------------
  assign div_last = 16'(OSC_DIV - 1);
  assign tick     = (div_q == div_last);

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      div_q <= 16'h0000;
    end else if (tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  assign need = (vmon_filt_t'(ctrl_q[BIT_FILT_HI:BIT_FILT_LO]) == FILT_MID)
                ? TICKS_MID :
                (vmon_filt_t'(ctrl_q[BIT_FILT_HI:BIT_FILT_LO]) == FILT_LONG)
                ? TICKS_LONG : TICKS_SHORT;

  vmon_filter u_filter (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .tick  (tick),
    .level (low_q),
    .need  (need),
    .hit   (hit)
  );

  // ----------------------------------------------------------------
  // Request flag, interrupt and wake
  // ----------------------------------------------------------------
  assign stat_d = hit || wr_set || (stat_q && !wr_clr);

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      stat_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      wake_q <= hit && !stat_q && IDLE_MODE;
    end
  end

  assign MONITOR_IRQ_REQUEST = stat_q;
  assign IRQ                 = stat_q && ien_q;
  assign WAKE_IDLE           = wake_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  property p_ext_sense;
    (ctrl_q[BIT_THR_HI:BIT_THR_LO] == THR_EXT) |-> SENSE_EXT;
  endproperty
  a_ext_sense: assert property (p_ext_sense)
    else $error("code zero does not pick external sense");

  property p_supply_sense;
    (THRESHOLD_SELECT != THR_EXT) |-> !SENSE_EXT;
  endproperty
  a_supply_sense: assert property (p_supply_sense)
    else $error("nonzero code does not pick supply");

  property p_flag_follow;
    (rd_take && (ARADDR == OFF_CTRL)) |=> (RDATA[BIT_FLAG] == $past(low_q))
      && (low_q == ($past(active) && $past(CMP_LOW)));
  endproperty
  a_flag_follow: assert property (p_flag_follow)
    else $error("low flag not set by low comparator");

  property p_enable_off;
    !ctrl_q[BIT_EN] |-> !MONITOR_ON ##1 !low_q;
  endproperty
  a_enable_off: assert property (p_enable_off)
    else $error("detector on while disabled");

  property p_ref_on;
    (LVR_ENABLE || MONITOR_ON) |-> REF_ON;
  endproperty
  a_ref_on: assert property (p_ref_on)
    else $error("reference off while needed");

  property p_sleep_off;
    SLEEP_MODE |-> !MONITOR_ON ##1 !low_q;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("detector active in sleep");

  property p_req_cause;
    $rose(stat_q) |-> $past(low_q) || $past(wr_set);
  endproperty
  a_req_cause: assert property (p_req_cause)
    else $error("request raised without low condition");

  property p_wake;
    (hit && !stat_q && IDLE_MODE) |=> WAKE_IDLE && stat_q;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake on new request in idle");

  property p_req_sticky;
    (stat_q && !wr_clr) |=> stat_q;
  endproperty
  a_req_sticky: assert property (p_req_sticky)
    else $error("request dropped without software clear");

endmodule
`default_nettype wire

// ---- sim/vmon_rail_model.sv ----
// Supply rail and external sense model feeding the comparator input.
// Assumes the bench sets both levels in millivolts.
`timescale 1ns/100ps
`default_nettype none
module vmon_rail_model (
  // Levels in millivolts
  input  wire logic [15:0] vdd_mv,
  input  wire logic [15:0] ext_mv,
  // Selection from the block
  input  wire logic        on,
  input  wire logic        ext,
  input  wire logic [2:0]  sel,
  // Comparator result
  output logic             low
);
  // ----------------------------------------------------------------
  // Threshold levels
  // ----------------------------------------------------------------
  localparam int LVL [8] = '{1230, 2200, 2400, 2700, 3000, 3300, 3600, 4000};
  // A switched-off comparator reports no low condition
  assign low = on & (ext ? (int'(ext_mv) < LVL[sel])
                         : (int'(vdd_mv) < LVL[sel]));
endmodule
`default_nettype wire

// ---- sim/test_vmon_ctrl.sv ----
// Self-checking bench for the voltage monitor control block.
// Assumes the rail model drives the comparator input.
`timescale 1ns/100ps
`default_nettype none
module test_vmon_ctrl;
  import vmon_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  localparam int D = 4;
  localparam int LV [8] = '{1230, 2200, 2400, 2700, 3000, 3300, 3600, 4000};
  logic        CLK_SYS = 0, RST_N = 0, AWVALID = 0, WVALID = 0, BREADY = 0;
  logic        ARVALID = 0, RREADY = 0, SLEEP_MODE = 0, IDLE_MODE = 0;
  logic        LVR_ENABLE = 0;
  logic [7:0]  AWADDR = 0, ARADDR = 0;
  logic [31:0] WDATA = 0;
  logic [3:0]  WSTRB = 0;
  logic [3:0]  strb = 4'hf;
  logic [15:0] vdd = 16'd5000, ext = 16'd2000;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, CMP_LOW, MONITOR_ON;
  logic        REF_ON, SENSE_EXT, MONITOR_IRQ_REQUEST, IRQ, WAKE_IDLE;
  logic [1:0]  BRESP, RRESP;
  logic [31:0] RDATA;
  logic [2:0]  THRESHOLD_SELECT;
  int          errors = 0, n_compared = 0, wake_n = 0, c, nt;

  always #2 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) if (WAKE_IDLE === 1'b1) wake_n <= wake_n + 1;

  vmon_ctrl #(.OSC_DIV(D)) dut_u (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .AWADDR(AWADDR), .AWPROT(3'h0), .WVALID(WVALID), .WREADY(WREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .BVALID(BVALID), .BREADY(BREADY),
    .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
    .ARPROT(3'h0), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
    .RRESP(RRESP), .SLEEP_MODE(SLEEP_MODE), .IDLE_MODE(IDLE_MODE),
    .LVR_ENABLE(LVR_ENABLE), .CMP_LOW(CMP_LOW), .MONITOR_ON(MONITOR_ON),
    .REF_ON(REF_ON), .SENSE_EXT(SENSE_EXT),
    .THRESHOLD_SELECT(THRESHOLD_SELECT),
    .MONITOR_IRQ_REQUEST(MONITOR_IRQ_REQUEST), .IRQ(IRQ),
    .WAKE_IDLE(WAKE_IDLE));

  vmon_rail_model rail_u (.vdd_mv(vdd), .ext_mv(ext), .on(MONITOR_ON),
    .ext(SENSE_EXT), .sel(THRESHOLD_SELECT), .low(CMP_LOW));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic hang;
    errors++;
    complete_run();
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge CLK_SYS);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    bit ad = 0, wd = 0, bd = 0;
    int n = 0;
    @(posedge CLK_SYS);
    AWVALID <= 1;
    AWADDR <= a;
    WVALID <= 1;
    WDATA <= d;
    WSTRB <= strb;
    BREADY <= 1;
    while (!bd) begin
      @(posedge CLK_SYS);
      n++;
      if (!ad && AWREADY === 1'b1) begin
        ad = 1;
        AWVALID <= 0;
      end
      if (!wd && WREADY === 1'b1) begin
        wd = 1;
        WVALID <= 0;
      end
      if (BVALID === 1'b1) begin
        bd = 1;
        BREADY <= 0;
        chk("bresp", 32'(BRESP), 32'(er));
      end
      if (n > 50) hang();
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    bit ad = 0, rd = 0;
    int n = 0;
    @(posedge CLK_SYS);
    ARVALID <= 1;
    ARADDR <= a;
    RREADY <= 1;
    while (!rd) begin
      @(posedge CLK_SYS);
      n++;
      if (!ad && ARREADY === 1'b1) begin
        ad = 1;
        ARVALID <= 0;
      end
      if (RVALID === 1'b1) begin
        rd = 1;
        RREADY <= 0;
        chk("rresp", 32'(RRESP), 32'(er));
        if (er == RESP_OK) chk("rdata", RDATA, e);
      end
      if (n > 50) hang();
    end
  endtask

  task automatic wait_req;
    c = 0;
    while (MONITOR_IRQ_REQUEST !== 1'b1) begin
      @(posedge CLK_SYS);
      c++;
      if (c > 200) hang();
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge CLK_SYS);
    RST_N <= 1;
    tick(1);
    chk("ref_on", 32'(REF_ON), 0);
    chk("sense_ext", 32'(SENSE_EXT), 1);
    rdc(OFF_CTRL, 0, RESP_OK);
    wr(OFF_CTRL, 32'hff, RESP_OK);
    rdc(OFF_CTRL, 32'hdf, RESP_OK);
    tick(1);
    chk("mon_on", 32'(MONITOR_ON), 1);
    chk("thr", 32'(THRESHOLD_SELECT), 7);
    wr(OFF_CTRL, 32'h08, RESP_OK);
    tick(1);
    chk("mon_on", 32'(MONITOR_ON), 0);
    chk("ref_on", 32'(REF_ON), 1);
    wr(OFF_CTRL, 0, RESP_OK);
    LVR_ENABLE <= 1;
    tick(1);
    chk("ref_on", 32'(REF_ON), 1);
    @(posedge CLK_SYS);
    LVR_ENABLE <= 0;
    tick(1);
    chk("ref_on", 32'(REF_ON), 0);
    // Each threshold just above and just below its level
    for (int k = 0; k < 8; k++) begin
      wr(OFF_CTRL, 32'h10 | k, RESP_OK);
      vdd <= (k == 0) ? 16'd1000 : 16'(LV[k] + 10);
      ext <= (k == 0) ? 16'(LV[0] + 10) : 16'd1000;
      tick(8);
      chk("sense_ext", 32'(SENSE_EXT), 32'(k == 0));
      rdc(OFF_CTRL, 32'h10 | k, RESP_OK);
      if (k == 0) ext <= 16'(LV[0] - 10);
      else vdd <= 16'(LV[k] - 10);
      tick(2);
      rdc(OFF_CTRL, 32'h30 | k, RESP_OK);
    end
    // Sleep holds the detector off
    @(posedge CLK_SYS);
    SLEEP_MODE <= 1;
    vdd <= 16'd1000;
    wr(OFF_CTRL, 32'h11, RESP_OK);
    wr(OFF_CLR, 1, RESP_OK);
    tick(40);
    chk("mon_on", 32'(MONITOR_ON), 0);
    chk("req", 32'(MONITOR_IRQ_REQUEST), 0);
    rdc(OFF_CTRL, 32'h11, RESP_OK);
    SLEEP_MODE <= 0;
    vdd <= 16'd5000;
    // Filter lengths, then the request holds after the rail recovers
    for (int f = 0; f < 4; f++) begin
      nt = (f == 2) ? 8 : (f == 1) ? 4 : 2;
      wr(OFF_CTRL, (f << 6) | 32'h11, RESP_OK);
      wr(OFF_CLR, 1, RESP_OK);
      tick(2);
      chk("req", 32'(MONITOR_IRQ_REQUEST), 0);
      @(posedge CLK_SYS);
      vdd <= 16'd1000;
      wait_req();
      chk("qual_lo", 32'(c > (nt - 1) * D), 1);
      chk("qual_hi", 32'(c <= nt * D + 4), 1);
      @(posedge CLK_SYS);
      vdd <= 16'd5000;
      tick(3 * D);
      chk("req_hold", 32'(MONITOR_IRQ_REQUEST), 1);
    end
    // Interrupt enable, mask and clear
    wr(OFF_IEN, 1, RESP_OK);
    tick(1);
    chk("irq", 32'(IRQ), 1);
    rdc(OFF_STAT, 1, RESP_OK);
    rdc(OFF_IEN, 1, RESP_OK);
    wr(OFF_IEN, 0, RESP_OK);
    tick(1);
    chk("irq", 32'(IRQ), 0);
    wr(OFF_IEN, 1, RESP_OK);
    wr(OFF_CLR, 1, RESP_OK);
    tick(1);
    chk("irq", 32'(IRQ), 0);
    rdc(OFF_STAT, 0, RESP_OK);
    // Wake from idle, then suppressed by a preset request
    @(posedge CLK_SYS);
    IDLE_MODE <= 1;
    vdd <= 16'd1000;
    wait_req();
    tick(3);
    chk("wake", 32'(wake_n), 1);
    vdd <= 16'd5000;
    wr(OFF_CLR, 1, RESP_OK);
    wr(OFF_SET, 1, RESP_OK);
    rdc(OFF_STAT, 1, RESP_OK);
    vdd <= 16'd1000;
    tick(16 * D);
    chk("wake", 32'(wake_n), 1);
    @(posedge CLK_SYS);
    IDLE_MODE <= 0;
    // Lane zero off leaves control alone; status ignores writes
    strb = 4'he;
    wr(OFF_CTRL, 0, RESP_OK);
    strb = 4'hf;
    rdc(OFF_CTRL, 32'hf1, RESP_OK);
    wr(OFF_STAT, 0, RESP_OK);
    rdc(OFF_STAT, 1, RESP_OK);
    // Unmapped address
    wr(8'h20, 1, RESP_ERR);
    rdc(8'h20, 0, RESP_ERR);
    complete_run();
  end
endmodule
`default_nettype wire
